// ### src/fpk_flash_protect.sv
// fpk_flash_protect: register file, command engine and access gating for two flash arrays.
// assumes an Avalon-MM master on sys_clk_i and flash access requests synchronous to it.
// assumes por_i only at power-on; reset_i alone reloads the saved deferred word.
// Function
// - read protect bit refuses debug/download reads
// - lower 31 bits guard four pages each
// - write protect blocks every access path
// - second array: 32 write protect bits
// - immediate register acts now, lost on reset
// - deferred word acts after save and reset
// - stored key must be presented again
// - mass erase restores the erased key
// - lock key refuses any later key write
// - locked protection removed only by mass erase
// - key command needs mode bit6 without bit5
// - status done/fail set, cleared by read
// - status busy follows the command engine
`timescale 1ns/10ps
module fpk_flash_protect #(
  parameter int CMD_CYCLES = fpk_pkg::CMD_CYCLES // cycles a command stays busy
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [fpk_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [fpk_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [fpk_pkg::BE_W-1:0] avs_byteenable,
  output logic [fpk_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // flash access gating
  input wire logic boot_select_pin_i,
  input wire logic acc_wr_req_i,
  input wire logic acc_rd_req_i,
  input wire logic acc_debug_i,
  input wire logic acc_block_i,
  input wire logic [fpk_pkg::PAGE_W-1:0] acc_page_i,
  output logic acc_wr_grant_o,
  output logic acc_rd_grant_o,
  // array erase and interrupt
  output logic mass_erase_o,
  output logic mass_erase_block_o,
  output logic irq_o
);
  import fpk_pkg::*;

  localparam int NB = NUM_BLOCKS;
  localparam logic [CNT_W-1:0] CMD_LAST = CNT_W'(CMD_CYCLES - 1); // counter load

  typedef struct packed {
    logic ack; // answer pending this cycle
    logic [DATA_W-1:0] rdata; // captured read data
    logic [NB-1:0][MOD_W-1:0] mode; // mode register per block
    logic [NB-1:0][CON_W-1:0] con; // last command
    logic [NB-1:0][HALF_W-1:0] dat; // data register
    logic [NB-1:0][HALF_W-1:0] adr; // address register
    logic [NB-1:0][DATA_W-1:0] pro; // deferred protection staging
    logic [NB-1:0][DATA_W-1:0] hid; // immediate protection
    logic [NB-1:0][STA_W-1:0] sta; // sticky status bits
    fpk_cmd_state_t [NB-1:0] fsm; // command engine
    logic [NB-1:0][CNT_W-1:0] cnt; // busy countdown
    logic [IRQ_W-1:0] irq_sta; // interrupt status
    logic [IRQ_W-1:0] irq_mask; // interrupt mask
    logic strap_taken; // boot select sampled
    logic dl_mode; // download mode since reset
    logic wr_grant; // program/erase allowed
    logic rd_grant; // read allowed
    logic mass_erase; // erase pulse to array
    logic erase_blk; // array being erased
  } fpk_state_t;

  fpk_state_t st_reg; // all state
  fpk_state_t st_next; // next state

  logic bus_take; // request accepted this edge
  logic [DATA_W-1:0] rd_value; // addressed register contents
  logic [DATA_W-1:0] wr_value; // write data merged by byte enables
  logic [NB-1:0] ks_commit; // save key pulse per block
  logic [NB-1:0] ks_erase; // mass erase pulse per block
  logic [NB-1:0] ks_key_ok; // key check per block
  logic [NB-1:0] ks_locked; // lock per block, until mass erase
  logic [NB-1:0][DATA_W-1:0] ks_active; // deferred word in force
  logic [NB-1:0][DATA_W-1:0] prot_eff; // combined protection
  logic [NB-1:0] page_ok; // write verdict per block
  logic [NB-1:0][DATA_W-1:0] present_key; // key offered in adr:dat
  logic [NB-1:0] cmd_busy; // engine busy per block

  // word-aligned match of the bus address
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // register offset inside block b
  function automatic logic [ADDR_W-1:0] blk_ofs(input int b, input logic [ADDR_W-1:0] ofs);
    blk_ofs = ADDR_W'(ofs + ADDR_W'(b) * BLOCK_STRIDE);
  endfunction

  // keep old bytes where the enable is low
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_w,
                                                 input logic [DATA_W-1:0] new_w,
                                                 input logic [BE_W-1:0] be);
    be_merge = old_w;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        be_merge[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
  endfunction

  // key command allowed: enable set, block bit clear, key accepted
  function automatic logic key_cmd_ok(input logic [MOD_W-1:0] mode, input logic key_ok);
    key_cmd_ok = mode[MOD_KEY_EN] && !mode[MOD_KEY_BLOCK] && key_ok;
  endfunction

  // mass erase allowed: erase enable and both erase keys in place
  function automatic logic erase_cmd_ok(input logic [MOD_W-1:0] mode,
                                        input logic [HALF_W-1:0] dat,
                                        input logic [HALF_W-1:0] adr);
    erase_cmd_ok = mode[MOD_ERASE_EN] && (dat == ERASE_DAT_KEY) && (adr == ERASE_ADR_KEY);
  endfunction

  // per block key store and page check
  for (genvar g = 0; g < NB; g++) begin : g_blk
    assign present_key[g] = {st_reg.adr[g], st_reg.dat[g]}; // 32-bit key in two halves
    assign prot_eff[g] = ks_active[g] & st_reg.hid[g]; // either part protects
    assign cmd_busy[g] = (st_reg.fsm[g] == FPK_EXEC);

    // saved key and word, reloaded into force at reset
    fpk_key_store u_key_store (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .por_i(por_i),
      .ce_i(ce_i),
      .commit_i(ks_commit[g]),
      .erase_i(ks_erase[g]),
      .new_prot_i(st_reg.pro[g]),
      .present_key_i(present_key[g]),
      .key_ok_o(ks_key_ok[g]),
      .locked_o(ks_locked[g]),
      .active_prot_o(ks_active[g])
    );

    // group verdict for program and erase
    fpk_page_check #(
      .HAS_FW_GROUP(g == 0)
    ) u_page_check (
      .prot_word_i(prot_eff[g]),
      .page_i(acc_page_i),
      .wr_ok_o(page_ok[g])
    );
  end

  // read mux of the addressed register
  always_comb begin
    rd_value = WORD_ZERO; // unmapped reads as zero
    for (int b = 0; b < NB; b++) begin
      if (hit(avs_address, blk_ofs(b, OFS_STA))) begin
        rd_value = DATA_W'(st_reg.sta[b]);
        rd_value[STA_BUSY] = cmd_busy[b]; // live busy flag
      end
      if (hit(avs_address, blk_ofs(b, OFS_MOD))) begin
        rd_value = DATA_W'(st_reg.mode[b]);
      end
      if (hit(avs_address, blk_ofs(b, OFS_CON))) begin
        rd_value = DATA_W'(st_reg.con[b]);
      end
      if (hit(avs_address, blk_ofs(b, OFS_DAT))) begin
        rd_value = DATA_W'(st_reg.dat[b]);
      end
      if (hit(avs_address, blk_ofs(b, OFS_ADR))) begin
        rd_value = DATA_W'(st_reg.adr[b]);
      end
      if (hit(avs_address, blk_ofs(b, OFS_PRO))) begin
        rd_value = st_reg.pro[b];
      end
      if (hit(avs_address, blk_ofs(b, OFS_HID))) begin
        rd_value = st_reg.hid[b];
      end
    end
    if (hit(avs_address, OFS_IRQ_STA)) begin
      rd_value = DATA_W'(st_reg.irq_sta);
    end
    if (hit(avs_address, OFS_IRQ_MASK)) begin
      rd_value = DATA_W'(st_reg.irq_mask);
    end
  end

  assign wr_value = be_merge(rd_value, avs_writedata, avs_byteenable);
  assign bus_take = st_reg.ack && (avs_read || avs_write);

  // bus, register writes, command engine, status and gating
  always_comb begin
    st_next = st_reg;
    ks_commit = '0;
    ks_erase = '0;
    st_next.ack = 1'b0;
    st_next.mass_erase = 1'b0;
    // one wait cycle, then the answer
    if ((avs_read || avs_write) && !st_reg.ack) begin
      st_next.ack = 1'b1;
      // writes leave the last read data standing
      if (avs_read) begin
        st_next.rdata = rd_value;
      end
    end
    // interrupt status: write one to clear, set wins below
    if (bus_take && avs_write && hit(avs_address, OFS_IRQ_STA)) begin
      st_next.irq_sta = st_reg.irq_sta & ~wr_value[IRQ_W-1:0];
    end
    if (bus_take && avs_write && hit(avs_address, OFS_IRQ_MASK)) begin
      st_next.irq_mask = wr_value[IRQ_W-1:0];
    end

    // per block: status clear, register writes, command engine
    for (int b = 0; b < NB; b++) begin
      // status read clears only what the reader saw
      if (bus_take && avs_read && hit(avs_address, blk_ofs(b, OFS_STA))) begin
        st_next.sta[b] = st_reg.sta[b] & ~(st_reg.rdata[STA_W-1:0] & STA_READ_CLR);
      end
      if (bus_take && avs_write) begin
        if (hit(avs_address, blk_ofs(b, OFS_MOD))) begin
          st_next.mode[b] = wr_value[MOD_W-1:0];
        end
        if (hit(avs_address, blk_ofs(b, OFS_DAT))) begin
          st_next.dat[b] = wr_value[HALF_W-1:0];
        end
        if (hit(avs_address, blk_ofs(b, OFS_ADR))) begin
          st_next.adr[b] = wr_value[HALF_W-1:0];
        end
        if (hit(avs_address, blk_ofs(b, OFS_PRO))) begin
          st_next.pro[b] = wr_value; // staged only, no effect yet
        end
        if (hit(avs_address, blk_ofs(b, OFS_HID))) begin
          st_next.hid[b] = wr_value; // set or clear at once
        end
      end
      unique case (st_reg.fsm[b])
        FPK_IDLE: begin
          // a command write starts the engine; ignored while busy
          if (bus_take && avs_write && hit(avs_address, blk_ofs(b, OFS_CON))) begin
            st_next.con[b] = wr_value[CON_W-1:0];
            st_next.fsm[b] = FPK_EXEC;
            st_next.cnt[b] = CMD_LAST;
          end
        end
        FPK_EXEC: begin
          if (st_reg.cnt[b] != CNT_ZERO) begin
            st_next.cnt[b] = st_reg.cnt[b] - 1'b1;
          end else begin
            // command ends: done always, fail unless the check passes
            st_next.fsm[b] = FPK_IDLE;
            st_next.sta[b][STA_DONE] = 1'b1;
            st_next.irq_sta[b] = 1'b1;
            if ((st_reg.con[b] == CMD_SAVE_KEY) && key_cmd_ok(st_reg.mode[b], ks_key_ok[b])) begin
              // key accepted: saved only, applied at the next reset
              ks_commit[b] = 1'b1;
            end else if ((st_reg.con[b] == CMD_MASS_ERASE) &&
                         erase_cmd_ok(st_reg.mode[b], st_reg.dat[b], st_reg.adr[b])) begin
              ks_erase[b] = 1'b1;
              st_next.mass_erase = 1'b1; // array clears its user code
              st_next.erase_blk = (b != 0); // which array is cleared
            end else begin
              // bad key, no enable or unknown code: nothing changes
              st_next.sta[b][STA_FAIL] = 1'b1; // set wins over the read clear
              st_next.irq_sta[NB+b] = 1'b1;
            end
            if (st_reg.mode[b][MOD_IRQ_EN]) begin
              st_next.sta[b][STA_IRQ] = 1'b1; // interrupt status on completion
            end
          end
        end
      endcase
    end

    // boot select caught once after reset
    if (!st_reg.strap_taken) begin
      st_next.strap_taken = 1'b1;
      st_next.dl_mode = !boot_select_pin_i;
    end

    // program/erase gated on every path
    st_next.wr_grant = acc_wr_req_i && page_ok[acc_block_i];
    // debug and download reads refused by the read protect bit
    st_next.rd_grant = acc_rd_req_i &&
                       (!(acc_debug_i || st_reg.dl_mode) || prot_eff[0][READ_PROT_BIT]);
  end

  // state register with clock enable
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      // bus answer
      st_reg.ack <= 1'b0;
      st_reg.rdata <= WORD_ZERO;
      // per block registers and engines
      for (int b = 0; b < NB; b++) begin
        st_reg.mode[b] <= MOD_RESET;
        st_reg.con[b] <= CON_RESET;
        st_reg.dat[b] <= HALF_RESET;
        st_reg.adr[b] <= HALF_RESET;
        st_reg.pro[b] <= PRO_RESET;
        st_reg.hid[b] <= PROT_NONE; // immediate protection lost
        st_reg.sta[b] <= STA_RESET;
        st_reg.fsm[b] <= FPK_IDLE;
        st_reg.cnt[b] <= CNT_ZERO;
      end
      // interrupt, strap and gating
      st_reg.irq_sta <= IRQ_RESET;
      st_reg.irq_mask <= IRQ_RESET;
      st_reg.strap_taken <= 1'b0;
      st_reg.dl_mode <= 1'b0;
      st_reg.wr_grant <= 1'b0;
      st_reg.rd_grant <= 1'b0;
      st_reg.mass_erase <= 1'b0;
      st_reg.erase_blk <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // bus answer: one wait cycle, data from the capture register
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
  assign avs_readdata = st_reg.rdata;

  // access verdicts, one cycle after the request
  assign acc_wr_grant_o = st_reg.wr_grant;
  assign acc_rd_grant_o = st_reg.rd_grant;

  // erase strobe, erased array and interrupt level
  assign mass_erase_o = st_reg.mass_erase;
  assign mass_erase_block_o = st_reg.erase_blk;
  assign irq_o = |(st_reg.irq_sta & st_reg.irq_mask);

endmodule // fpk_flash_protect

// ### pkg/fpk_pkg.sv
// fpk_pkg: register map, field positions, keys and command codes of the flash protection block.
// assumes a 32-bit Avalon-MM slave with byte addresses and one register per aligned word.
package fpk_pkg;

  // bus and array geometry
  localparam int NUM_BLOCKS = 2; // two 64 kB flash arrays
  localparam int ADDR_W = 9; // byte address width of the slave
  localparam int DATA_W = 32; // bus data width
  localparam int BE_W = 4; // byte enables
  localparam int PAGE_W = 7; // 128 pages of 512 bytes per array
  localparam int GROUP_W = 5; // 32 groups of four pages
  localparam int GROUP_SHIFT = 2; // page to group: drop two bits
  localparam int MOD_W = 8; // mode register width
  localparam int CON_W = 8; // command register width
  localparam int HALF_W = 16; // address and data register width
  localparam int STA_W = 4; // stored status bits
  localparam int CNT_W = 8; // command execution counter width
  localparam int IRQ_W = 4; // done0, done1, fail0, fail1

  // register byte offsets within one block, and the block stride
  localparam logic [ADDR_W-1:0] OFS_STA = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_MOD = 9'h004;
  localparam logic [ADDR_W-1:0] OFS_CON = 9'h008;
  localparam logic [ADDR_W-1:0] OFS_DAT = 9'h00C;
  localparam logic [ADDR_W-1:0] OFS_ADR = 9'h010;
  localparam logic [ADDR_W-1:0] OFS_PRO = 9'h01C;
  localparam logic [ADDR_W-1:0] OFS_HID = 9'h020;
  localparam logic [ADDR_W-1:0] BLOCK_STRIDE = 9'h080;
  // interrupt status and mask, shared by both blocks
  localparam logic [ADDR_W-1:0] OFS_IRQ_STA = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 9'h104;

  // status bits
  localparam int STA_DONE = 0;
  localparam int STA_FAIL = 1;
  localparam int STA_BUSY = 2;
  localparam int STA_IRQ = 3;
  localparam logic [STA_W-1:0] STA_READ_CLR = 4'hB; // bits cleared by a status read

  // mode bits
  localparam int MOD_ERASE_EN = 3;
  localparam int MOD_IRQ_EN = 4;
  localparam int MOD_KEY_BLOCK = 5;
  localparam int MOD_KEY_EN = 6;

  // reset values
  localparam logic [MOD_W-1:0] MOD_RESET = 8'h80;
  localparam logic [CON_W-1:0] CON_RESET = 8'h00;
  localparam logic [HALF_W-1:0] HALF_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PRO_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PROT_NONE = 32'hFFFF_FFFF; // protect bits are active low
  localparam logic [STA_W-1:0] STA_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // commands and keys
  localparam logic [CON_W-1:0] CMD_MASS_ERASE = 8'h06;
  localparam logic [CON_W-1:0] CMD_SAVE_KEY = 8'h0C;
  localparam logic [HALF_W-1:0] ERASE_DAT_KEY = 16'h3CFF;
  localparam logic [HALF_W-1:0] ERASE_ADR_KEY = 16'hFFC3;
  localparam logic [DATA_W-1:0] KEY_ERASED = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] KEY_LOCK = 32'hDEAD_DEAD;

  // protection word layout
  localparam int READ_PROT_BIT = 31;
  localparam logic [GROUP_W-1:0] FW_GROUP = 5'h1F; // firmware group of the first array

  // command execution time in cycles
  localparam int CMD_CYCLES = 16;

  // command engine state of one block
  typedef enum logic {
    FPK_IDLE,
    FPK_EXEC
  } fpk_cmd_state_t;

endpackage

// ### src/fpk_page_check.sv
// fpk_page_check: decides whether a program or erase may touch a page of one array.
// assumes an active-low protection word already combined from deferred and immediate parts.
`timescale 1ns/10ps
module fpk_page_check #(
  parameter bit HAS_FW_GROUP = 1'b0 // top group holds hidden firmware
) (
  // protection and request
  input wire logic [fpk_pkg::DATA_W-1:0] prot_word_i,
  input wire logic [fpk_pkg::PAGE_W-1:0] page_i,
  // verdict
  output logic wr_ok_o
);
  import fpk_pkg::*;

  logic [GROUP_W-1:0] group; // four pages per protect bit

  // page to group, then test the active-low bit
  always_comb begin
    group = page_i[PAGE_W-1:GROUP_SHIFT];
    wr_ok_o = prot_word_i[group];
    if (HAS_FW_GROUP && (group == FW_GROUP)) begin
      wr_ok_o = 1'b0; // top bit is read protect, group stays firmware
    end
  end

endmodule // fpk_page_check

// ### src/fpk_key_store.sv
// fpk_key_store: saved key, saved protection word and the protection applied since reset.
// assumes por_i marks power-on only; reset_i reloads the applied word from the saved one.
`timescale 1ns/10ps
module fpk_key_store (
  // clock, resets, enable
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic ce_i,
  // commands from the engine
  input wire logic commit_i,
  input wire logic erase_i,
  input wire logic [fpk_pkg::DATA_W-1:0] new_prot_i,
  input wire logic [fpk_pkg::DATA_W-1:0] present_key_i,
  // verdicts and protection
  output logic key_ok_o,
  output logic locked_o,
  output logic [fpk_pkg::DATA_W-1:0] active_prot_o
);
  import fpk_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] key; // saved key
    logic [DATA_W-1:0] saved; // saved protection word
    logic [DATA_W-1:0] active; // word in force since reset
  } fpk_ks_state_t;

  fpk_ks_state_t ks_reg; // all state
  fpk_ks_state_t ks_next; // next state

  // key check and update of saved values
  always_comb begin
    ks_next = ks_reg;
    locked_o = (ks_reg.key == KEY_LOCK);
    key_ok_o = !locked_o && ((ks_reg.key == KEY_ERASED) || (ks_reg.key == present_key_i));
    if (erase_i) begin
      ks_next.key = KEY_ERASED; // mass erase forgets the key
      ks_next.saved = PROT_NONE;
      ks_next.active = PROT_NONE;
    end else if (commit_i && key_ok_o) begin
      ks_next.key = present_key_i; // saved, applied only at next reset
      ks_next.saved = new_prot_i;
    end
  end

  // power-on clears, reset applies the saved word
  always_ff @(posedge sys_clk_i) begin
    if (por_i) begin
      ks_reg.key <= KEY_ERASED;
      ks_reg.saved <= PROT_NONE;
      ks_reg.active <= PROT_NONE;
    end else if (reset_i) begin
      ks_reg.active <= ks_reg.saved;
    end else if (ce_i) begin
      ks_reg <= ks_next;
    end
  end

  assign active_prot_o = ks_reg.active;

endmodule // fpk_key_store

// ### verification/fpk_flash_protect_assertions.sv
// fpk_flash_protect_assertions: port-level checks of the flash protection block.
// assumes a bind onto fpk_flash_protect, one clock, sync active-high reset.
`timescale 1ns/10ps
module fpk_chk
  import fpk_pkg::*;
(
  // clock and controls
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic boot_select_pin_i,
  // avalon-mm slave
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [fpk_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // access gating
  input wire logic acc_wr_req_i,
  input wire logic acc_rd_req_i,
  input wire logic acc_debug_i,
  input wire logic acc_block_i,
  input wire logic [fpk_pkg::PAGE_W-1:0] acc_page_i,
  input wire logic acc_wr_grant_o,
  input wire logic acc_rd_grant_o,
  input wire logic mass_erase_o
);
  // one domain: shared clock and disable
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // bus handshake: wait only under a request, one wait cycle
  AST_WAIT_ONLY_REQ: assert property (avs_waitrequest |-> (avs_read || avs_write))
    else $error("waitrequest without request");
  AST_WAIT_FIRST: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait");
  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest && ce_i
    |=> !avs_waitrequest || !(avs_read || avs_write))
    else $error("more than one wait cycle");
  // read data only move after a read or a reset
  AST_RDATA_STANDS: assert property ($changed(avs_readdata) |-> $past(avs_read) || $past(reset_i))
    else $error("readdata changed without read");
  // gating of program, erase and read
  AST_NO_WR_GRANT: assert property (!acc_wr_req_i && ce_i |=> !acc_wr_grant_o)
    else $error("write grant without request");
  AST_FW_GROUP: assert property (acc_wr_req_i && !acc_block_i && ce_i
    && acc_page_i[PAGE_W-1:GROUP_SHIFT] == FW_GROUP |=> !acc_wr_grant_o)
    else $error("firmware group write granted");
  AST_NO_RD_GRANT: assert property (!acc_rd_req_i && ce_i |=> !acc_rd_grant_o)
    else $error("read grant without request");
  AST_RD_OPEN: assert property (acc_rd_req_i && !acc_debug_i && boot_select_pin_i && ce_i
    |=> acc_rd_grant_o)
    else $error("user read refused");
  // erase strobe lasts one cycle
  AST_ERASE_PULSE: assert property (mass_erase_o && ce_i |=> !mass_erase_o)
    else $error("erase pulse too long");
endmodule // fpk_chk

bind fpk_flash_protect fpk_chk chk_u (.sys_clk_i, .reset_i, .ce_i, .boot_select_pin_i, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .acc_wr_req_i, .acc_rd_req_i, .acc_debug_i,
  .acc_block_i, .acc_page_i, .acc_wr_grant_o, .acc_rd_grant_o, .mass_erase_o);

// ### verification/fpk_flash_protect_tb.sv
// fpk_flash_protect_tb: register, key, erase, interrupt and gating scenarios.
// assumes the checker is bound; commands shortened to two cycles.
`timescale 1ns/10ps
module fpk_flash_protect_tb;
  import fpk_pkg::*;
  localparam logic [31:0] K1 = 32'h1234_5678; // user key
  localparam logic [31:0] P4 = 32'hFFFF_FFFD; // pages 4..7 guarded
  logic sys_clk_i, reset_i, por_i, ce_i, avs_read, avs_write, avs_waitrequest, irq_o;
  logic boot_select_pin_i, acc_wr_req_i, acc_rd_req_i, acc_debug_i, acc_block_i;
  logic acc_wr_grant_o, acc_rd_grant_o, mass_erase_o, mass_erase_block_o;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [BE_W-1:0] avs_byteenable;
  logic [PAGE_W-1:0] acc_page_i;
  int num_errors, n_checks, n_erase;

  fpk_flash_protect #(.CMD_CYCLES(2)) dut_u (.sys_clk_i, .reset_i, .por_i, .ce_i, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .boot_select_pin_i, .acc_wr_req_i, .acc_rd_req_i, .acc_debug_i, .acc_block_i, .acc_page_i,
    .acc_wr_grant_o, .acc_rd_grant_o, .mass_erase_o, .mass_erase_block_o, .irq_o);

  // 20 MHz clock
  initial begin
    sys_clk_i = 0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // count erase strobes
  always @(posedge sys_clk_i) if (mass_erase_o === 1'b1) n_erase++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon cycle, held until waitrequest low
  task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(0, a, 0, q);
    chk(q, exp);
  endtask
  // one access request, grant seen a cycle later
  task acc(input logic b, input logic [6:0] p, input logic w, input logic dbg, input logic exp);
    @(posedge sys_clk_i);
    acc_block_i <= b;
    acc_page_i <= p;
    acc_wr_req_i <= w;
    acc_rd_req_i <= !w;
    acc_debug_i <= dbg;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, w ? acc_wr_grant_o : acc_rd_grant_o}, {31'h0, exp});
    @(posedge sys_clk_i);
    acc_wr_req_i <= 0;
    acc_rd_req_i <= 0;
  endtask
  // command on block 0, status polled until done or fail
  task cmd(input logic [7:0] m, input logic [31:0] k, input logic [7:0] c, input logic [31:0] exp);
    logic [31:0] q;
    int n;
    wr(OFS_MOD, {24'h0, m});
    wr(OFS_ADR, {16'h0, k[31:16]});
    wr(OFS_DAT, {16'h0, k[15:0]});
    wr(OFS_CON, {24'h0, c});
    n = 0;
    do begin
      bus(0, OFS_STA, 0, q);
      n++;
    end while (q[1:0] == 2'b00 && n < 50);
    chk(q, exp);
  endtask
  task key(input logic [31:0] pro, input logic [7:0] m, input logic [31:0] k, input logic [31:0] exp);
    wr(OFS_PRO, pro);
    cmd(m, k, CMD_SAVE_KEY, exp);
  endtask
  task erase;
    cmd(8'h08, {ERASE_ADR_KEY, ERASE_DAT_KEY}, CMD_MASS_ERASE, 32'h1);
  endtask
  task irq(input logic exp);
    @(negedge sys_clk_i);
    chk({31'h0, irq_o}, {31'h0, exp});
  endtask
  task do_reset;
    @(posedge sys_clk_i);
    reset_i <= 1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 0;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (10000) @(posedge sys_clk_i);
    num_errors++;
    print_verdict;
  end

  // main sequence
  initial begin
    {avs_read, avs_write, acc_wr_req_i, acc_rd_req_i, acc_debug_i, acc_block_i} = '0;
    {avs_address, avs_writedata, acc_page_i} = '0;
    {reset_i, por_i, ce_i, boot_select_pin_i} = 4'hF;
    avs_byteenable = 4'hF;
    {num_errors, n_checks, n_erase} = '0;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 0;
    por_i <= 0;
    rd(OFS_HID, PROT_NONE);
    rd(OFS_PRO, PRO_RESET);
    rd(OFS_MOD, 32'h80);
    rd(9'h0F0, 0);
    acc(0, 4, 1, 0, 1);
    acc(0, 124, 1, 0, 0);
    wr(OFS_HID, P4);
    acc(0, 4, 1, 0, 0);
    acc(0, 3, 1, 0, 1);
    acc(0, 8, 1, 0, 1);
    acc(0, 7, 1, 1, 0);
    wr(OFS_HID, 32'h7FFF_FFFF);
    acc(0, 4, 1, 0, 1);
    acc(0, 9, 0, 1, 0);
    acc(0, 9, 0, 0, 1);
    wr(BLOCK_STRIDE + OFS_HID, 32'h7FFF_FFFF);
    acc(1, 124, 1, 0, 0);
    acc(1, 120, 1, 0, 1);
    do_reset;
    acc(1, 124, 1, 0, 1);
    acc(0, 9, 0, 1, 1);
    key(P4, 8'h48, K1, 32'h1);
    acc(0, 4, 1, 0, 1);
    key(PROT_NONE, 8'h48, 32'h1111_1111, 32'h3);
    key(PROT_NONE, 8'h68, K1, 32'h3);
    key(PROT_NONE, 8'h08, K1, 32'h3);
    cmd(8'h10, 32'h0, 8'h00, 32'hB);
    rd(OFS_STA, 0);
    rd(OFS_IRQ_STA, 32'h5);
    wr(OFS_IRQ_MASK, 32'h4);
    irq(1);
    wr(OFS_IRQ_MASK, 32'h2);
    irq(0);
    wr(OFS_IRQ_STA, 32'h4);
    rd(OFS_IRQ_STA, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    irq(1);
    wr(OFS_IRQ_STA, 32'h1);
    irq(0);
    do_reset;
    acc(0, 4, 1, 0, 0);
    key(PROT_NONE, 8'h48, K1, 32'h1);
    do_reset;
    acc(0, 4, 1, 0, 1);
    erase;
    chk(32'(n_erase), 1);
    key(P4, 8'h48, KEY_LOCK, 32'h1);
    do_reset;
    acc(0, 4, 1, 0, 0);
    key(PROT_NONE, 8'h48, KEY_LOCK, 32'h3);
    do_reset;
    acc(0, 4, 1, 0, 0);
    erase;
    acc(0, 4, 1, 0, 1);
    chk(32'(n_erase), 2);
    wr(BLOCK_STRIDE + OFS_ADR, {16'h0, ERASE_ADR_KEY});
    wr(BLOCK_STRIDE + OFS_DAT, {16'h0, ERASE_DAT_KEY});
    wr(BLOCK_STRIDE + OFS_MOD, 32'h8);
    wr(BLOCK_STRIDE + OFS_CON, {24'h0, CMD_MASS_ERASE});
    repeat (4) @(posedge sys_clk_i);
    chk({31'h0, mass_erase_block_o}, 32'h1);
    chk(32'(n_erase), 3);
    print_verdict;
  end
endmodule // fpk_flash_protect_tb
